/* dv/event_bus_router_sva.sv */
module event_bus_router_sva #(
   parameter int NUM_CH = 2
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // Register bus
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   // Pins and lines
   input wire logic EVENT_INPUT_ONE,
   input wire logic EVENT_INPUT_TWO,
   input wire logic [routing_pkg::NUM_LINES-1:0] SHARED_LINE_IN,
   input wire logic [routing_pkg::NUM_LINES-1:0] SHARED_LINE_OUT,
   input wire logic [routing_pkg::NUM_LINES-1:0] SHARED_LINE_OE,
   // Modes and interrupt
   input routing_pkg::chan_mode_s [NUM_CH-1:0] CHANNEL_MODE,
   input wire logic IRQ
);
   default clocking @(posedge SYS_CLK);
   endclocking
   default disable iff (RESET);
   logic req;
   assign req = AVS_READ || AVS_WRITE;
   // Nothing that steers a mode moved
   sequence s_quiet;
      !AVS_WRITE && $stable(EVENT_INPUT_ONE) && $stable(EVENT_INPUT_TWO)
         && $stable(SHARED_LINE_IN);
   endsequence
   a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST)
      else $error("no wait state in first request cycle");
   a_wait_one: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("more than one wait state");
   a_read_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
      else $error("read data moved without a read");
   a_line_pair: assert property (SHARED_LINE_OUT == SHARED_LINE_OE)
      else $error("line drive and enable differ");
   a_irq_fall: assert property ($fell(IRQ) |-> $past(AVS_WRITE))
      else $error("interrupt dropped without a write");
   a_sync_delay: assert property (s_quiet [*6] ##1 !AVS_WRITE [*2] |=>
      $stable(CHANNEL_MODE))
      else $error("mode moved too soon or without cause");
   a_irq_quiet: assert property (s_quiet [*6] ##1 !AVS_WRITE |=> !$rose(IRQ))
      else $error("interrupt without cause");
   a_reset_idle: assert property ($fell(RESET) |-> !IRQ && SHARED_LINE_OE == '0
      && CHANNEL_MODE == '0)
      else $error("outputs not idle after reset");
endmodule

bind event_bus_router event_bus_router_sva #(.NUM_CH(NUM_CH)) i_event_bus_router_sva (
   .SYS_CLK, .RESET, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST,
   .EVENT_INPUT_ONE, .EVENT_INPUT_TWO, .SHARED_LINE_IN, .SHARED_LINE_OUT,
   .SHARED_LINE_OE, .CHANNEL_MODE, .IRQ);

/* dv/event_bus_router_test.sv */
module event_bus_router_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, rd = 0, wr = 0, ev1 = 0, ev2 = 0, wait_r, irq;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [2:0] lout, loe, lin, other = 3'h0;
   logic [15:0] stat = 16'h0;
   routing_pkg::chan_mode_s [1:0] mode;
   int n_mismatch = 0, num_checks = 0;
   event_bus_router #(.NUM_CH(2)) i_event_bus_router (.SYS_CLK(clk), .RESET(rst),
      .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hf),
      .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
      .EVENT_INPUT_ONE(ev1), .EVENT_INPUT_TWO(ev2), .SHARED_LINE_IN(lin),
      .SHARED_LINE_OUT(lout), .SHARED_LINE_OE(loe), .DEVICE_STATUS(stat),
      .CHANNEL_FLAGS('0), .CHANNEL_MODE(mode), .IRQ(irq));
   line_partner i_line_partner (.own_out(lout), .own_oe(loe), .other(other), .line(lin));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Request held until a rising edge sees no wait; read data taken there
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      @(posedge clk);
      while (wait_r !== 1'b0) begin
         n++;
         if (n > 20) begin
            n_mismatch++;
            $display("wrong value at %0t: bus timeout", $time);
            complete_run();
         end
         @(posedge clk);
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Sync, load and register all fit in five edges
   task automatic gap;
      repeat (5) @(posedge clk);
   endtask
   task automatic s_defaults;
      bus(0, 8'h00, 0);
      chk(q, 0);
      bus(0, 8'h3c, 0);
      chk(q, 0);
      chk(mode, 0);
   endtask
   task automatic s_limits;
      bus(1, 8'h00, 32'h46);
      gap();
      chk(irq, 0);
      bus(1, 8'h30, 32'h20);
      gap();
      chk(irq, 1);
      bus(1, 8'h2c, 32'h20);
      gap();
      chk(irq, 0);
      bus(0, 8'h00, 0);
      chk(q, 0);
      bus(1, 8'h00, 32'h45);
      bus(0, 8'h00, 0);
      chk(q, 32'h45);
      bus(1, 8'h08, 32'h46);
      bus(0, 8'h08, 0);
      chk(q, 0);
   endtask
   task automatic s_run;
      bus(1, 8'h00, 32'h3);
      @(posedge clk) ev1 <= 1'b1;
      gap();
      chk(mode[0].run, 0);
      bus(1, 8'h20, 32'h8);
      gap();
      chk({mode[1].run, mode[0].run}, 2'h3);
      bus(1, 8'h04, 32'h5);
      bus(0, 8'h04, 0);
      chk(q, 0);
      @(posedge clk) ev1 <= 1'b0;
      gap();
      chk(mode[0].run, 0);
      bus(1, 8'h04, 32'h4);
      bus(1, 8'h20, 32'h8);
      gap();
      chk(mode[1].run, 1);
      @(posedge clk) ev2 <= 1'b1;
      gap();
      chk(mode[1].run, 0);
   endtask
   task automatic s_bank;
      bus(1, 8'h00, 32'h1);
      bus(1, 8'h04, 32'h2);
      bus(1, 8'h20, 32'h8);
      gap();
      chk(mode[0].bank, 2'h2);
      @(posedge clk) ev1 <= 1'b1;
      gap();
      chk(mode[1].bank, 2'h3);
   endtask
   task automatic s_remote;
      bus(1, 8'h00, 32'h11);
      bus(1, 8'h04, 32'h6);
      bus(1, 8'h20, 32'h8);
      gap();
      chk({mode[1].manual, mode[0].manual}, 2'h2);
      chk(mode[0].remote, 0);
      bus(1, 8'h20, 32'h9);
      gap();
      chk({mode[1].remote, mode[0].remote}, 2'h3);
   endtask
   task automatic s_lines;
      for (int i = 0; i < 6; i++) bus(1, 8'h08 + 8'(4*i), 0);
      bus(1, 8'h08, 32'h3);
      bus(1, 8'h14, 32'h1);
      bus(1, 8'h20, 32'ha);
      @(posedge clk) stat <= 16'h4000;
      gap();
      chk(lout, 0);
      @(posedge clk) stat <= 16'h2000;
      gap();
      chk(lout, 3'h1);
      chk(loe, 3'h1);
      chk(mode[0].run, 1);
      @(posedge clk) stat <= 16'h0001;
      gap();
      chk(lout, 3'h1);
      @(posedge clk) stat <= 16'h0;
      gap();
      chk(mode[0].run, 0);
      @(posedge clk) other <= 3'h1;
      gap();
      chk(mode[1].run, 1);
      @(posedge clk) other <= 3'h0;
      bus(1, 8'h20, 32'he);
      @(posedge clk) other <= 3'h1;
      gap();
      chk(mode[0].run, 0);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      s_defaults();
      s_limits();
      s_run();
      s_bank();
      s_remote();
      s_lines();
      complete_run();
   end
endmodule

/* dv/line_partner.sv */
module line_partner (
   // Own unit drive
   input wire logic [routing_pkg::NUM_LINES-1:0] own_out,
   input wire logic [routing_pkg::NUM_LINES-1:0] own_oe,
   // Other units
   input wire logic [routing_pkg::NUM_LINES-1:0] other,
   // Combined level
   output logic [routing_pkg::NUM_LINES-1:0] line
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle lines pulled low, so released means 0
   assign line = (own_out & own_oe) | other;
endmodule

/* rtl/edge_sync.sv */
module edge_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Asynchronous levels in
   input wire logic [WIDTH-1:0] din,
   // Synchronised level and change pulse
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] changed
);

   logic [WIDTH-1:0] meta_q, meta_d;
   logic [WIDTH-1:0] sync_q, sync_d;
   logic [WIDTH-1:0] prev_q, prev_d;
   logic [2:0] fill_q, fill_d;

   always_comb begin
      meta_d = din;
      sync_d = meta_q;
      prev_d = sync_q;
      fill_d = {fill_q[1:0], 1'b1};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
         fill_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
         fill_q <= fill_d;
      end
   end

   // Both directions count as a change
   assign level = sync_q;
   // Pipe filling after reset is no pin change; a pin high at reset
   // would otherwise flag a false edge
   assign changed = (sync_q ^ prev_q) & {WIDTH{fill_q[2]}};

endmodule

/* rtl/event_bus_router.sv */
module event_bus_router #(
   parameter int NUM_CH = 2
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // Avalon-MM slave
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Event input pins
   input wire logic EVENT_INPUT_ONE,
   input wire logic EVENT_INPUT_TWO,
   // Shared wired-OR lines
   input wire logic [routing_pkg::NUM_LINES-1:0] SHARED_LINE_IN,
   output logic [routing_pkg::NUM_LINES-1:0] SHARED_LINE_OUT,
   output logic [routing_pkg::NUM_LINES-1:0] SHARED_LINE_OE,
   // Controller state
   input wire logic [15:0] DEVICE_STATUS,
   input routing_pkg::chan_flags_s [NUM_CH-1:0] CHANNEL_FLAGS,
   output routing_pkg::chan_mode_s [NUM_CH-1:0] CHANNEL_MODE,
   // Interrupt
   output logic IRQ
);

   localparam int NS = routing_pkg::NUM_SOURCES;
   localparam int NE = routing_pkg::NUM_EVENTS;
   localparam int NL = routing_pkg::NUM_LINES;
   localparam int CW = routing_pkg::CODE_W;
   localparam logic [CW-1:0] IN_MAX =
      (NUM_CH == 4) ? routing_pkg::BUS_IN_MAX_4CH : routing_pkg::BUS_IN_MAX_2CH;
   localparam logic [CW-1:0] OUT_MAX =
      (NUM_CH == 4) ? routing_pkg::BUS_OUT_MAX_4CH : routing_pkg::BUS_OUT_MAX_2CH;

   if (NUM_CH != 2 && NUM_CH != 4) begin : g_bad_ch
      $error("NUM_CH must be 2 or 4");
   end

   // Maps an input assignment code to its function and channel set
   function automatic routing_pkg::route_s decode_in(input logic [CW-1:0] code,
                                                      input int nch);
      routing_pkg::route_s r;
      logic [CW-1:0] rel;
      logic [CW-1:0] ch;
      logic [CW-1:0] fn;
      r.func = routing_pkg::FN_NONE;
      r.chmask = '0;
      rel = '0;
      ch = '0;
      fn = '0;
      if (code >= 8'h01 && code < routing_pkg::IN_CHAN_BASE) begin
         r.func = routing_pkg::input_func_e'(code[2:0]);
         r.chmask = '1;
      end else if (code >= routing_pkg::IN_CHAN_BASE) begin
         rel = code - routing_pkg::IN_CHAN_BASE;
         ch = rel / routing_pkg::IN_FUNCS_PER_CHAN;
         fn = rel % routing_pkg::IN_FUNCS_PER_CHAN;
         if (ch < CW'(nch)) begin
            r.func = routing_pkg::input_func_e'(fn[2:0] + 3'h1);
            r.chmask[ch[1:0]] = 1'b1;
         end
      end
      return r;
   endfunction

   // Byte-lane merge of a write into the current value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return m;
   endfunction

   // Synchronised inputs
   logic [NS-1:0] src_level;
   logic [NS-1:0] src_changed;

   edge_sync #(.WIDTH(NS)) u_sync (
      .clk(SYS_CLK),
      .rst(RESET),
      .din({SHARED_LINE_IN, EVENT_INPUT_TWO, EVENT_INPUT_ONE}),
      .level(src_level),
      .changed(src_changed)
   );

   // State
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic [CW-1:0] ev_shadow_q [NE], ev_shadow_d [NE];
   logic [CW-1:0] in_shadow_q [NL], in_shadow_d [NL];
   logic [CW-1:0] out_shadow_q [NL], out_shadow_d [NL];
   logic [CW-1:0] ev_active_q [NE], ev_active_d [NE];
   logic [CW-1:0] in_active_q [NL], in_active_d [NL];
   logic [CW-1:0] out_active_q [NL], out_active_d [NL];
   logic [2:0] ctrl_q, ctrl_d;
   logic [1:0] settle_q, settle_d;
   routing_pkg::chan_mode_s [NUM_CH-1:0] mode_q, mode_d;
   logic [NL-1:0] drive_q, drive_d;
   logic [routing_pkg::IRQ_W-1:0] irq_status_q, irq_status_d;
   logic [routing_pkg::IRQ_W-1:0] irq_mask_q, irq_mask_d;

   // Decoded bus access
   logic req;
   logic wr_fire;
   logic [31:0] old_word;
   logic [31:0] wr_word;
   logic running;
   logic load;
   logic started;
   logic bus_in_ok;
   logic ctrl_error;
   logic refused;
   logic [31:0] state_word;

   assign req = AVS_READ | AVS_WRITE;
   assign wr_fire = AVS_WRITE & ack_q;
   assign load = (settle_q == 2'h1);
   assign started = (settle_q == 2'h0);
   assign bus_in_ok = ctrl_q[routing_pkg::CTRL_SUPPORT_POS] &
                      ~ctrl_q[routing_pkg::CTRL_DISTRIBUTED_POS];
   assign ctrl_error = |DEVICE_STATUS[routing_pkg::ERROR_HIGH_BIT:routing_pkg::ERROR_LOW_BIT];

   always_comb begin
      running = 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
         running = running | mode_q[c].run;
      end
   end

   always_comb begin
      state_word = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         state_word[routing_pkg::ST_RUN_POS + c] = mode_q[c].run;
         state_word[routing_pkg::ST_MANUAL_POS + c] = mode_q[c].manual;
         state_word[routing_pkg::ST_REMOTE_POS + c] = mode_q[c].remote;
         state_word[routing_pkg::ST_BANK_POS + 2*c +: 2] = mode_q[c].bank;
      end
      state_word[routing_pkg::ST_LINE_POS +: NL] = src_level[NS-1:NE];
      state_word[routing_pkg::ST_EVENT_POS +: NE] = src_level[NE-1:0];
      state_word[routing_pkg::ST_ERROR_POS] = ctrl_error;
   end

   // Read mux, also the old value for byte-lane merging
   always_comb begin
      old_word = '0;
      for (int i = 0; i < NE; i++) begin
         if (AVS_ADDRESS == routing_pkg::OFS_EVENT_ASSIGN + 8'(4*i)) begin
            old_word = {24'h000000, ev_shadow_q[i]};
         end
      end
      for (int i = 0; i < NL; i++) begin
         if (AVS_ADDRESS == routing_pkg::OFS_BUS_IN_ASSIGN + 8'(4*i)) begin
            old_word = {24'h000000, in_shadow_q[i]};
         end
         if (AVS_ADDRESS == routing_pkg::OFS_BUS_OUT_ASSIGN + 8'(4*i)) begin
            old_word = {24'h000000, out_shadow_q[i]};
         end
      end
      if (AVS_ADDRESS == routing_pkg::OFS_CONTROL) begin
         old_word = {29'h00000000, ctrl_q};
      end
      if (AVS_ADDRESS == routing_pkg::OFS_STATE || AVS_ADDRESS == routing_pkg::OFS_COMMAND) begin
         old_word = state_word;
      end
      if (AVS_ADDRESS == routing_pkg::OFS_IRQ_STATUS) begin
         old_word = {26'h0000000, irq_status_q};
      end
      if (AVS_ADDRESS == routing_pkg::OFS_IRQ_MASK) begin
         old_word = {26'h0000000, irq_mask_q};
      end
      wr_word = merge(old_word, AVS_WRITEDATA, AVS_BYTEENABLE);
   end

   // Bus handshake: one wait cycle, read data captured in it
   always_comb begin
      ack_d = req & ~ack_q;
      rdata_d = rdata_q;
      if (AVS_READ & ~ack_q) begin
         rdata_d = old_word;
      end
   end

   // Assignment registers, control and settle sequencing
   always_comb begin
      ev_shadow_d = ev_shadow_q;
      in_shadow_d = in_shadow_q;
      out_shadow_d = out_shadow_q;
      ev_active_d = ev_active_q;
      in_active_d = in_active_q;
      out_active_d = out_active_q;
      ctrl_d = ctrl_q;
      settle_d = (settle_q != 2'h0) ? settle_q - 2'h1 : settle_q;
      refused = 1'b0;
      if (wr_fire) begin
         for (int i = 0; i < NE; i++) begin
            if (AVS_ADDRESS == routing_pkg::OFS_EVENT_ASSIGN + 8'(4*i)) begin
               if (running || wr_word[CW-1:0] > routing_pkg::EVENT_CODE_MAX) begin
                  refused = 1'b1;
               end else begin
                  ev_shadow_d[i] = wr_word[CW-1:0];
               end
            end
         end
         for (int i = 0; i < NL; i++) begin
            if (AVS_ADDRESS == routing_pkg::OFS_BUS_IN_ASSIGN + 8'(4*i)) begin
               if (running || wr_word[CW-1:0] > IN_MAX) begin
                  refused = 1'b1;
               end else begin
                  in_shadow_d[i] = wr_word[CW-1:0];
               end
            end
            if (AVS_ADDRESS == routing_pkg::OFS_BUS_OUT_ASSIGN + 8'(4*i)) begin
               if (running || wr_word[CW-1:0] > OUT_MAX) begin
                  refused = 1'b1;
               end else begin
                  out_shadow_d[i] = wr_word[CW-1:0];
               end
            end
         end
         if (AVS_ADDRESS == routing_pkg::OFS_CONTROL) begin
            ctrl_d = wr_word[2:0];
            if (wr_word[routing_pkg::CTRL_SOFT_RESET_POS]) begin
               // New settings only take over here, then levels re-apply
               ev_active_d = ev_shadow_q;
               in_active_d = in_shadow_q;
               out_active_d = out_shadow_q;
               settle_d = routing_pkg::SETTLE_CYCLES;
            end
         end
      end
   end

   // Channel modes: commands, then input functions in source order
   always_comb begin
      routing_pkg::route_s r;
      logic ok;
      r = '0;
      ok = 1'b0;
      mode_d = mode_q;
      if (wr_fire && AVS_ADDRESS == routing_pkg::OFS_COMMAND) begin
         for (int c = 0; c < NUM_CH; c++) begin
            mode_d[c].run = wr_word[routing_pkg::ST_RUN_POS + c];
            mode_d[c].manual = wr_word[routing_pkg::ST_MANUAL_POS + c];
            mode_d[c].remote = wr_word[routing_pkg::ST_REMOTE_POS + c] &
                               ctrl_q[routing_pkg::CTRL_REMOTE_ALLOW_POS];
            mode_d[c].bank = wr_word[routing_pkg::ST_BANK_POS + 2*c +: 2];
         end
      end
      for (int s = 0; s < NS; s++) begin
         r = decode_in((s < NE) ? ev_active_q[s] : in_active_q[s-NE],
                       (s < NE) ? 2 : NUM_CH);
         // Startup load applies levels even without an edge
         ok = (load | src_changed[s]) & ((s < NE) | bus_in_ok);
         for (int c = 0; c < NUM_CH; c++) begin
            if (ok && r.chmask[c]) begin
               unique case (r.func)
                  routing_pkg::FN_NONE: begin
                  end
                  routing_pkg::FN_BANK0: begin
                     mode_d[c].bank[0] = src_level[s];
                  end
                  routing_pkg::FN_BANK1: begin
                     mode_d[c].bank[1] = src_level[s];
                  end
                  routing_pkg::FN_STOP_RUN: begin
                     mode_d[c].run = src_level[s];
                  end
                  routing_pkg::FN_RUN_STOP: begin
                     mode_d[c].run = ~src_level[s];
                  end
                  routing_pkg::FN_AUTO_MANUAL: begin
                     mode_d[c].manual = src_level[s];
                  end
                  routing_pkg::FN_LOCAL_REMOTE: begin
                     if (ctrl_q[routing_pkg::CTRL_REMOTE_ALLOW_POS]) begin
                        mode_d[c].remote = src_level[s];
                     end
                  end
               endcase
            end
         end
      end
   end

   // Line drive: this unit's share of the wired-OR
   always_comb begin
      logic [routing_pkg::OUT_GLOBAL_N-1:0] glob;
      logic [routing_pkg::OUT_CHAN_N-1:0] chsrc [routing_pkg::MAX_CHANNELS];
      logic [CW-1:0] rel;
      logic [CW-1:0] ch;
      logic [CW-1:0] fn;
      glob = '0;
      rel = '0;
      ch = '0;
      fn = '0;
      for (int c = 0; c < routing_pkg::MAX_CHANNELS; c++) begin
         chsrc[c] = '0;
      end
      glob[1] = ctrl_error;
      glob[3] = 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
         chsrc[c] = {mode_q[c].remote, mode_q[c].manual, ~mode_q[c].run, mode_q[c].run,
                     mode_q[c].bank, CHANNEL_FLAGS[c].heater_overcurrent_alarm,
                     CHANNEL_FLAGS[c].heater_short_alarm, CHANNEL_FLAGS[c].heater_burnout_alarm,
                     CHANNEL_FLAGS[c].remote_setpoint_input_error,
                     CHANNEL_FLAGS[c].input_error, &CHANNEL_FLAGS[c].alarm,
                     |CHANNEL_FLAGS[c].alarm, CHANNEL_FLAGS[c].alarm};
         glob[2] = glob[2] | chsrc[c][3];
         glob[3] = glob[3] & chsrc[c][4];
         glob[6:4] = glob[6:4] | chsrc[c][2:0];
         glob[11:7] = glob[11:7] | chsrc[c][9:5];
      end
      glob[13:12] = src_level[NE-1:0];
      glob[16:14] = src_level[NS-1:NE] & {NL{bus_in_ok}};
      for (int l = 0; l < NL; l++) begin
         drive_d[l] = 1'b0;
         if (out_active_q[l] < routing_pkg::OUT_CHAN_BASE) begin
            drive_d[l] = glob[out_active_q[l][4:0]];
         end else begin
            rel = out_active_q[l] - routing_pkg::OUT_CHAN_BASE;
            ch = rel / routing_pkg::OUT_FUNCS_PER_CHAN;
            fn = rel % routing_pkg::OUT_FUNCS_PER_CHAN;
            if (ch < CW'(NUM_CH)) begin
               drive_d[l] = chsrc[ch[1:0]][fn[3:0]];
            end
         end
      end
   end

   // Interrupts: set wins over write-one-to-clear
   always_comb begin
      logic [routing_pkg::IRQ_W-1:0] set;
      set = '0;
      set[routing_pkg::IRQ_EVENT_POS +: NE] = src_changed[NE-1:0] & {NE{started}};
      set[routing_pkg::IRQ_LINE_POS +: NL] = src_changed[NS-1:NE] & {NL{started}};
      set[routing_pkg::IRQ_REFUSED_POS] = refused;
      irq_status_d = irq_status_q;
      irq_mask_d = irq_mask_q;
      if (wr_fire && AVS_ADDRESS == routing_pkg::OFS_IRQ_STATUS) begin
         irq_status_d = irq_status_q & ~wr_word[routing_pkg::IRQ_W-1:0];
      end
      if (wr_fire && AVS_ADDRESS == routing_pkg::OFS_IRQ_MASK) begin
         irq_mask_d = wr_word[routing_pkg::IRQ_W-1:0];
      end
      irq_status_d = irq_status_d | set;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
         for (int i = 0; i < NE; i++) begin
            ev_shadow_q[i] <= routing_pkg::ASSIGN_RESET;
            ev_active_q[i] <= routing_pkg::ASSIGN_RESET;
         end
         for (int i = 0; i < NL; i++) begin
            in_shadow_q[i] <= routing_pkg::ASSIGN_RESET;
            in_active_q[i] <= routing_pkg::ASSIGN_RESET;
            out_shadow_q[i] <= routing_pkg::ASSIGN_RESET;
            out_active_q[i] <= routing_pkg::ASSIGN_RESET;
         end
         ctrl_q <= routing_pkg::CTRL_RESET;
         settle_q <= routing_pkg::SETTLE_CYCLES;
         mode_q <= '0;
         drive_q <= '0;
         irq_status_q <= routing_pkg::IRQ_RESET;
         irq_mask_q <= routing_pkg::IRQ_RESET;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         ev_shadow_q <= ev_shadow_d;
         ev_active_q <= ev_active_d;
         in_shadow_q <= in_shadow_d;
         in_active_q <= in_active_d;
         out_shadow_q <= out_shadow_d;
         out_active_q <= out_active_d;
         ctrl_q <= ctrl_d;
         settle_q <= settle_d;
         mode_q <= mode_d;
         drive_q <= drive_d;
         irq_status_q <= irq_status_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   assign AVS_WAITREQUEST = req & ~ack_q;
   assign AVS_READDATA = rdata_q;
   // Wired-OR: drive high only when asserting, otherwise release
   assign SHARED_LINE_OUT = drive_q;
   assign SHARED_LINE_OE = drive_q;
   assign CHANNEL_MODE = mode_q;
   assign IRQ = |(irq_status_q & irq_mask_q);

endmodule

/* rtl/routing_pkg.sv */
package routing_pkg;

   // Counts and widths
   localparam int NUM_EVENTS = 2;
   localparam int NUM_LINES = 3;
   localparam int NUM_SOURCES = NUM_EVENTS + NUM_LINES;
   localparam int MAX_CHANNELS = 4;
   localparam int CODE_W = 8;

   // Register byte offsets; assignment registers are arrays of words
   localparam logic [7:0] OFS_EVENT_ASSIGN = 8'h00;
   localparam logic [7:0] OFS_BUS_IN_ASSIGN = 8'h08;
   localparam logic [7:0] OFS_BUS_OUT_ASSIGN = 8'h14;
   localparam logic [7:0] OFS_CONTROL = 8'h20;
   localparam logic [7:0] OFS_COMMAND = 8'h24;
   localparam logic [7:0] OFS_STATE = 8'h28;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h2c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

   // Control register fields
   localparam int CTRL_REMOTE_ALLOW_POS = 0;
   localparam int CTRL_SUPPORT_POS = 1;
   localparam int CTRL_DISTRIBUTED_POS = 2;
   localparam int CTRL_SOFT_RESET_POS = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // Command and state register fields, four channel slots each
   localparam int ST_RUN_POS = 0;
   localparam int ST_MANUAL_POS = 4;
   localparam int ST_REMOTE_POS = 8;
   localparam int ST_BANK_POS = 12;
   localparam int ST_LINE_POS = 20;
   localparam int ST_EVENT_POS = 23;
   localparam int ST_ERROR_POS = 25;

   // Interrupt status bits
   localparam int IRQ_EVENT_POS = 0;
   localparam int IRQ_LINE_POS = 2;
   localparam int IRQ_REFUSED_POS = 5;
   localparam int IRQ_W = 6;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;

   // Assignment code limits and layout
   localparam logic [CODE_W-1:0] ASSIGN_RESET = 8'h00;
   localparam logic [CODE_W-1:0] EVENT_CODE_MAX = 8'h45;
   localparam logic [CODE_W-1:0] BUS_IN_MAX_2CH = 8'h45;
   localparam logic [CODE_W-1:0] BUS_IN_MAX_4CH = 8'h84;
   localparam logic [CODE_W-1:0] BUS_OUT_MAX_2CH = 8'h57;
   localparam logic [CODE_W-1:0] BUS_OUT_MAX_4CH = 8'h96;
   localparam logic [CODE_W-1:0] IN_CHAN_BASE = 8'h07;
   localparam logic [CODE_W-1:0] IN_FUNCS_PER_CHAN = 8'h06;
   localparam logic [CODE_W-1:0] OUT_CHAN_BASE = 8'h11;
   localparam logic [CODE_W-1:0] OUT_FUNCS_PER_CHAN = 8'h10;
   localparam int OUT_GLOBAL_N = 17;
   localparam int OUT_CHAN_N = 16;

   // Status word bits that raise the controller-error source
   localparam int ERROR_LOW_BIT = 0;
   localparam int ERROR_HIGH_BIT = 13;

   // Cycles the synchronisers need before startup levels are valid
   localparam logic [1:0] SETTLE_CYCLES = 2'h2;

   typedef enum logic [2:0] {
      FN_NONE,
      FN_BANK0,
      FN_BANK1,
      FN_STOP_RUN,
      FN_RUN_STOP,
      FN_AUTO_MANUAL,
      FN_LOCAL_REMOTE
   } input_func_e;

   typedef struct packed {
      input_func_e func;
      logic [MAX_CHANNELS-1:0] chmask;
   } route_s;

   typedef struct packed {
      logic [2:0] alarm;
      logic input_error;
      logic remote_setpoint_input_error;
      logic heater_burnout_alarm;
      logic heater_short_alarm;
      logic heater_overcurrent_alarm;
   } chan_flags_s;

   typedef struct packed {
      logic run;
      logic manual;
      logic remote;
      logic [1:0] bank;
   } chan_mode_s;

endpackage
